// File: tcc_core.sv
/*
 six-channel timer counter core: clock selection, enable/start control,
 32-bit counters, capture b and compare c events, io line direction.
 assumes a single MCLK domain, pins arriving asynchronously, and a master
 that strobes WR or RD for one cycle with address and data beside it.
*/
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module tcc_core
	import tcc_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [AW-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic SLOW_CLOCK,
	input wire logic [NCH-1:0] CLOCK_PIN,
	input wire logic [NCH-1:0] IO_LINE_A_IN,
	output logic [NCH-1:0] IO_LINE_A_OUT,
	output logic [NCH-1:0] IO_LINE_A_OE,
	input wire logic [NCH-1:0] IO_LINE_B_IN,
	output logic [NCH-1:0] IO_LINE_B_OUT,
	output logic [NCH-1:0] IO_LINE_B_OE,
	output logic IRQ
);
	tcc_state_type st;
	tcc_state_type n;
	logic [NPIN-1:0] raw;
	logic [NCH-1:0] xc_lvl;
	logic [NCH-1:0] io_line_a_lvl;
	logic [NCH-1:0] cnt_ev;
	logic [NCH-1:0] sel_ev;
	logic [NCH-1:0] gate;
	logic [NCH-1:0] trig;
	logic [NCH-1:0] rise_a;
	logic [NCH-1:0] rise_b;
	logic [NGRP-1:0] sync_wr;
	logic [2:0] chsel;
	logic is_blk;
	logic [5:0] off;

	// edge of an internal divided tick, the slow clock or an xc line
	function automatic logic clk_edge(input tcc_mode_type m, input logic [6:0] pre,
		input logic lvl, input logic prev);
		logic [6:0] mk;
		logic r;
		logic f;
		mk = PRE_MASK[m.clock_source_select[1:0]];
		if (m.clock_source_select < CSS_SLOW) begin
			r = ((pre & mk) == mk);
			f = ((pre & mk) == (mk >> 1));
		end else begin
			r = lvl & ~prev;
			f = ~lvl & prev;
		end
		return m.clock_invert ? f : r;
	endfunction

	assign raw = {SLOW_CLOCK, IO_LINE_B_IN, IO_LINE_A_IN, CLOCK_PIN};

	// address split: group, channel slot, register offset
	assign off = ADDR[5:0];
	assign is_blk = (ADDR[7:6] == BLOCK_SLOT);
	assign chsel = ADDR[8] ? (3'(ADDR[7:6]) + 3'(CPG)) : 3'(ADDR[7:6]);

	always_comb begin
		n = st;
		n.s1 = raw;
		n.s2 = st.s1;
		n.s3 = st.s2;
		n.flt = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.flt);
		n.pre = st.pre + 7'h01;
		n.rdata = '0;
		n.irq = 1'b0;
		for (int g = 0; g < NGRP; g++) begin
			sync_wr[g] = WR && is_blk && (ADDR[8] == g[0]) && (off == OFF_BCMD)
				&& WDATA[BCMD_SYNC];
		end
		for (int c = 0; c < NCH; c++) begin
			io_line_a_lvl[c] = st.oea[c] ? st.ch[c].outa : n.flt[PIN_A + c];
			rise_a[c] = n.flt[PIN_A + c] & ~st.flt[PIN_A + c];
			rise_b[c] = n.flt[PIN_B + c] & ~st.flt[PIN_B + c];
		end
		// xc routing: clock pin or io line a of the next channel
		for (int c = 0; c < NCH; c++) begin
			if (st.bmode[c / CPG][c % CPG])
				xc_lvl[c] = io_line_a_lvl[(c / CPG) * CPG + ((c % CPG) + 1) % CPG];
			else
				xc_lvl[c] = n.flt[c];
		end
		n.xc_prev = xc_lvl;
		// block mode register writes
		if (WR && is_blk && off == OFF_BMODE)
			n.bmode[ADDR[8]] = WDATA[2:0];
		for (int c = 0; c < NCH; c++) begin
			int g;
			int xs;
			logic lv;
			logic pv;
			logic cmdw;
			logic hit;
			lv = 1'b0;
			pv = 1'b0;
			g = c / CPG;
			hit = !is_blk && (chsel == 3'(c));
			cmdw = WR && hit && (off == OFF_CMD);
			// source mux: slow clock or one xc input
			xs = g * CPG + int'(st.ch[c].mode.clock_source_select - CSS_XC0);
			if (st.ch[c].mode.clock_source_select == CSS_SLOW) begin
				lv = n.flt[PIN_SLOW];
				pv = st.flt[PIN_SLOW];
			end else if (st.ch[c].mode.clock_source_select >= CSS_XC0) begin
				lv = xc_lvl[xs];
				pv = st.xc_prev[xs];
			end else begin
				lv = 1'b0;
				pv = 1'b0;
			end
			sel_ev[c] = clk_edge(st.ch[c].mode, st.pre, lv, pv);
			// burst gating on a chosen xc level
			gate[c] = (st.ch[c].mode.burst == 2'h0)
				|| xc_lvl[g * CPG + int'(st.ch[c].mode.burst) - 1];
			cnt_ev[c] = sel_ev[c] && gate[c] && st.ch[c].clock_enable_command && st.ch[c].run;
			// software, sync and external triggers
			trig[c] = (cmdw && WDATA[CMD_SWTRG]) || sync_wr[g]
				|| (st.ch[c].mode.ext_trig_en && rise_b[c]
				&& (!st.ch[c].mode.wave || st.ch[c].mode.b_is_event));
			// status read clears overflow; a new wrap below wins
			if (RD && hit && off == OFF_STAT)
				n.ch[c].ovf = 1'b0;
			if (cnt_ev[c]) begin
				if (st.ch[c].pend) begin
					n.ch[c].cv = '0;
					n.ch[c].pend = 1'b0;
				end else begin
					n.ch[c].cv = st.ch[c].cv + 32'h1;
					if (st.ch[c].cv == CV_MAX)
						n.ch[c].ovf = 1'b1;
				end
			end
			// waveform compare c on the counting edge
			if (st.ch[c].mode.wave && cnt_ev[c] && !st.ch[c].pend
				&& st.ch[c].cv == st.ch[c].rc) begin
				n.ch[c].outa = ~st.ch[c].outa;
				if (st.ch[c].mode.compare_c_halts)
					n.ch[c].run = 1'b0;
				if (st.ch[c].mode.compare_c_disables)
					n.ch[c].clock_enable_command = 1'b0;
			end
			// capture b load on rising io line a in capture mode
			if (!st.ch[c].mode.wave && rise_a[c]) begin
				n.ch[c].rb = st.ch[c].cv;
				if (st.ch[c].mode.load_b_halts)
					n.ch[c].run = 1'b0;
				if (st.ch[c].mode.load_b_disables)
					n.ch[c].clock_enable_command = 1'b0;
			end
			if (trig[c] && st.ch[c].clock_enable_command) begin
				n.ch[c].run = 1'b1;
				n.ch[c].pend = 1'b1;
			end
			// enable then disable command, disable wins
			if (cmdw && WDATA[CMD_EN])
				n.ch[c].clock_enable_command = 1'b1;
			if (cmdw && WDATA[CMD_DIS])
				n.ch[c].clock_enable_command = 1'b0;
			// mode and compare c writes
			if (WR && hit && off == OFF_MODE) begin
				n.ch[c].mode = tcc_mode_type'(WDATA[15:0]);
				n.ch[c].mode.rsv = '0;
			end
			if (WR && hit && off == OFF_RC)
				n.ch[c].rc = WDATA;
			n.oea[c] = st.ch[c].mode.wave;
			n.oeb[c] = st.ch[c].mode.wave && !st.ch[c].mode.b_is_event;
			n.outb[c] = 1'b0;
			// channel overflow feeds the shared line
			n.irq = n.irq | st.ch[c].ovf;
		end
		// live reads, data valid the following cycle only
		if (RD) begin
			if (is_blk) begin
				if (off == OFF_BMODE)
					n.rdata = 32'(st.bmode[ADDR[8]]);
			end else if (chsel < 3'(NCH)) begin
				case (off)
					OFF_MODE: n.rdata = 32'(st.ch[chsel].mode);
					OFF_CV: n.rdata = st.ch[chsel].cv;
					OFF_RB: n.rdata = st.ch[chsel].rb;
					OFF_RC: n.rdata = st.ch[chsel].rc;
					OFF_STAT: begin
						n.rdata[STAT_OVF] = st.ch[chsel].ovf;
						n.rdata[STAT_CLOCK_ENABLED_STATUS] = st.ch[chsel].clock_enable_command;
					end
					default: n.rdata = '0;
				endcase
			end
		end
	end

	// all six channels held in one state register
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			st <= '0;
		end else begin
			st <= n;
		end
	end

	// outputs straight from state flip-flops
	assign RDATA = st.rdata;
	assign IO_LINE_A_OUT = {st.ch[5].outa, st.ch[4].outa, st.ch[3].outa,
		st.ch[2].outa, st.ch[1].outa, st.ch[0].outa};
	assign IO_LINE_A_OE = st.oea;
	assign IO_LINE_B_OUT = st.outb;
	assign IO_LINE_B_OE = st.oeb;
	assign IRQ = st.irq;

	// checks on channel 0
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);

	logic cmd0;
	logic rd_cv0;
	logic rd_st0;
	assign cmd0 = WR && ADDR == {3'h0, OFF_CMD};
	assign rd_cv0 = RD && ADDR == {3'h0, OFF_CV};
	assign rd_st0 = RD && ADDR == {3'h0, OFF_STAT};

	sequence s_plain_edge;
		cnt_ev[0] && !st.ch[0].pend;
	endsequence
	sequence s_trig_edge;
		cnt_ev[0] && st.ch[0].pend;
	endsequence

	property p_count;
		s_plain_edge ##0 (st.ch[0].cv != CV_MAX) |=> st.ch[0].cv == $past(st.ch[0].cv) + 32'h1;
	endproperty
	a_count: assert property (p_count) else $error("counter did not advance");

	property p_wrap;
		s_plain_edge ##0 (st.ch[0].cv == CV_MAX) |=> st.ch[0].cv == 32'h0 && st.ch[0].ovf;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap did not flag overflow");

	property p_live;
		rd_cv0 |=> RDATA == $past(st.ch[0].cv);
	endproperty
	a_live: assert property (p_live) else $error("counter read not live");

	property p_trig;
		s_trig_edge ##0 !trig[0] |=> st.ch[0].cv == 32'h0 && !st.ch[0].pend;
	endproperty
	a_trig: assert property (p_trig) else $error("trigger reset missed");

	property p_en;
		cmd0 && WDATA[CMD_EN] && !WDATA[CMD_DIS] |=> st.ch[0].clock_enable_command;
	endproperty
	a_en: assert property (p_en) else $error("enable command ignored");

	property p_dis;
		cmd0 && WDATA[CMD_DIS] |=> !st.ch[0].clock_enable_command;
	endproperty
	a_dis: assert property (p_dis) else $error("disable command ignored");

	property p_hold;
		!st.ch[0].clock_enable_command && !st.ch[0].run |=> !st.ch[0].run;
	endproperty
	a_hold: assert property (p_hold) else $error("start while disabled");

	property p_stat;
		rd_st0 |=> RDATA[STAT_CLOCK_ENABLED_STATUS] == $past(st.ch[0].clock_enable_command);
	endproperty
	a_stat: assert property (p_stat) else $error("enabled status wrong");

	property p_cap_oe;
		!st.ch[0].mode.wave |=> !IO_LINE_A_OE[0] && !IO_LINE_B_OE[0];
	endproperty
	a_cap_oe: assert property (p_cap_oe) else $error("capture mode drives a line");

	property p_wave_oe;
		st.ch[0].mode.wave |=> IO_LINE_A_OE[0] && IO_LINE_B_OE[0] == !$past(st.ch[0].mode.b_is_event);
	endproperty
	a_wave_oe: assert property (p_wave_oe) else $error("waveform direction wrong");

	property p_irq;
		st.ch[0].ovf |=> IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("overflow not on interrupt");

	property p_sync;
		WR && ADDR == {1'b0, BLOCK_SLOT, OFF_BCMD} && WDATA[BCMD_SYNC] && st.ch[0].clock_enable_command
			|=> st.ch[0].pend && st.ch[0].run;
	endproperty
	a_sync: assert property (p_sync) else $error("sync did not trigger");

	// compare c match on a plain counting edge in waveform mode
	sequence s_cpc_match;
		s_plain_edge ##0 (st.ch[0].mode.wave && st.ch[0].cv == st.ch[0].rc);
	endsequence

	property p_cpc_halt;
		s_cpc_match ##0 (st.ch[0].mode.compare_c_halts && !trig[0]) |=> !st.ch[0].run;
	endproperty
	a_cpc_halt: assert property (p_cpc_halt) else $error("compare c did not halt");

	property p_cpc_dis;
		s_cpc_match ##0 (st.ch[0].mode.compare_c_disables && !(cmd0 && WDATA[CMD_EN])) |=> !st.ch[0].clock_enable_command;
	endproperty
	a_cpc_dis: assert property (p_cpc_dis) else $error("compare c did not disable");

	property p_cpc_toggle;
		s_cpc_match |=> IO_LINE_A_OUT[0] != $past(IO_LINE_A_OUT[0]);
	endproperty
	a_cpc_toggle: assert property (p_cpc_toggle) else $error("line a did not toggle");

	// rising io line a in capture mode loads capture b
	sequence s_cap_load;
		!st.ch[0].mode.wave && rise_a[0];
	endsequence

	property p_ldb_load;
		s_cap_load |=> st.ch[0].rb == $past(st.ch[0].cv);
	endproperty
	a_ldb_load: assert property (p_ldb_load) else $error("capture b not loaded");

	property p_ldb_dis;
		s_cap_load ##0 (st.ch[0].mode.load_b_disables && !(cmd0 && WDATA[CMD_EN])) |=> !st.ch[0].clock_enable_command;
	endproperty
	a_ldb_dis: assert property (p_ldb_dis) else $error("capture b did not disable");

	property p_ext_trig;
		st.ch[0].mode.ext_trig_en && !st.ch[0].mode.wave && rise_b[0] && st.ch[0].clock_enable_command
			|=> st.ch[0].pend && st.ch[0].run;
	endproperty
	a_ext_trig: assert property (p_ext_trig) else $error("external trigger missed");

	property p_rd_idle;
		!RD |=> RDATA == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
endmodule

// File: tcc_pkg.sv
/*
 package for the six-channel timer counter core: register offsets, field
 layouts, pin indexes and the packed state carried by the core.
 assumes one 10 MHz peripheral clock and a plain strobe register port.
*/
// Behaviour
// - each channel counts up its 32-bit counter on selected clock edges
// - wrap from all ones to zero sets the overflow flag
// - counter reads return the live value without stopping it
// - a trigger zeroes the counter at the next valid clock edge
// - block mode routes each external clock from a pin or io line a
// - source select picks master clock /2 /8 /32 /128, slow clock or xc0-2
// - clock invert counts on the opposite edge
// - burst gates counting while a chosen external clock is high
// - enable and disable commands switch the counting clock
// - capture mode: capture b load disables clock when option set
// - waveform mode: compare c match disables clock when option set
// - while disabled starts do nothing, but a capture b load halt still stops; only enable restores
// - status shows the clock enabled bit
// - any trigger starts the clock when enabled
// - capture b load or compare c match halts clock when option set
// - mode bit selects capture or waveform per channel
// - capture mode drives neither io line
// - waveform drives io line a, and b unless b is the trigger
// - six identical channels in two groups of three
// - channel overflow events feed one interrupt line
// - block sync command triggers all channels of the group
package tcc_pkg;
	localparam int NCH = 6;
	localparam int NGRP = 2;
	localparam int CPG = 3;
	localparam int NPIN = 19;
	localparam int PIN_A = 6;
	localparam int PIN_B = 12;
	localparam int PIN_SLOW = 18;
	localparam int AW = 9;
	localparam logic [5:0] OFF_CMD = 6'h00;
	localparam logic [5:0] OFF_MODE = 6'h04;
	localparam logic [5:0] OFF_CV = 6'h10;
	localparam logic [5:0] OFF_RB = 6'h18;
	localparam logic [5:0] OFF_RC = 6'h1c;
	localparam logic [5:0] OFF_STAT = 6'h20;
	localparam logic [5:0] OFF_BCMD = 6'h00;
	localparam logic [5:0] OFF_BMODE = 6'h04;
	localparam logic [1:0] BLOCK_SLOT = 2'h3;
	localparam int CMD_EN = 0;
	localparam int CMD_DIS = 1;
	localparam int CMD_SWTRG = 2;
	localparam int BCMD_SYNC = 0;
	localparam int STAT_OVF = 0;
	localparam int STAT_CLOCK_ENABLED_STATUS = 16;
	localparam logic [2:0] CSS_SLOW = 3'h4;
	localparam logic [2:0] CSS_XC0 = 3'h5;
	localparam logic [31:0] CV_MAX = 32'hffffffff;
	localparam logic [6:0] PRE_MASK [4] = '{7'h01, 7'h07, 7'h1f, 7'h7f};

	typedef struct packed {
		logic wave;
		logic [2:0] rsv;
		logic compare_c_disables;
		logic compare_c_halts;
		logic b_is_event;
		logic ext_trig_en;
		logic load_b_disables;
		logic load_b_halts;
		logic [1:0] burst;
		logic clock_invert;
		logic [2:0] clock_source_select;
	} tcc_mode_type;

	typedef struct packed {
		logic [31:0] cv;
		logic [31:0] rb;
		logic [31:0] rc;
		tcc_mode_type mode;
		logic clock_enable_command;
		logic run;
		logic pend;
		logic ovf;
		logic outa;
	} tcc_chan_type;

	typedef struct packed {
		logic [NPIN-1:0] s1;
		logic [NPIN-1:0] s2;
		logic [NPIN-1:0] s3;
		logic [NPIN-1:0] flt;
		logic [6:0] pre;
		logic [NCH-1:0] xc_prev;
		logic [NGRP-1:0][2:0] bmode;
		tcc_chan_type [NCH-1:0] ch;
		logic [31:0] rdata;
		logic [NCH-1:0] oea;
		logic [NCH-1:0] oeb;
		logic [NCH-1:0] outb;
		logic irq;
	} tcc_state_type;
endpackage

// File: tcc_ext_model.sv
/*
 far-side model of the timer core: external clock pins, io lines, slow clock.
 assumes one MCLK domain; the bench calls pulse to make pin edges.
*/
`timescale 1ns/1ps
module tcc_ext_model
	import tcc_pkg::*;
(
	input wire logic mclk,
	input wire logic [NCH-1:0] a_out,
	input wire logic [NCH-1:0] a_oe,
	input wire logic [NCH-1:0] b_out,
	input wire logic [NCH-1:0] b_oe,
	output logic slow_clock,
	output logic [NCH-1:0] clock_pin,
	output logic [NCH-1:0] a_in,
	output logic [NCH-1:0] b_in
);
	logic [NCH-1:0] a_drv = '0;
	logic [NCH-1:0] b_drv = '0;
	logic [NCH-1:0] pin_drv = '0;
	logic [4:0] sdiv = '0;
	assign clock_pin = pin_drv;
	// slow clock runs free at an arbitrary mclk/32
	always @(posedge mclk) begin
		sdiv <= sdiv + 5'h01;
	end
	assign slow_clock = sdiv[4];
	// wire level: the core wins while it drives
	assign a_in = (a_oe & a_out) | (~a_oe & a_drv);
	assign b_in = (b_oe & b_out) | (~b_oe & b_drv);
	// sel 0 clock pin, 1 io line a, 2 io line b
	task automatic set_line(input int sel, input int idx, input logic v);
		case (sel)
			0: pin_drv[idx] <= v;
			1: a_drv[idx] <= v;
			default: b_drv[idx] <= v;
		endcase
	endtask
	task automatic pulse(input int sel, input int idx, input int k);
		repeat (k) begin
			repeat (8) @(posedge mclk);
			set_line(sel, idx, 1'b1);
			repeat (8) @(posedge mclk);
			set_line(sel, idx, 1'b0);
		end
		repeat (8) @(posedge mclk);
	endtask
endmodule

// File: timer_channel_clock_counter_tb.sv
/*
 self-checking bench for the timer core: register tasks, counting, control.
 assumes the far-side model and registered read data one cycle after RD.
*/
`timescale 1ns/1ps
module timer_channel_clock_counter_tb;
	import tcc_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [AW-1:0] addr = '0;
	logic [31:0] wdata = '0;
	logic [31:0] rdata, d, e;
	logic slow_clock, irq, lvl;
	logic [NCH-1:0] clock_pin, a_in, a_out, a_oe, b_in, b_out, b_oe;
	int n_errors = 0;
	int n_tests = 0;
	int seed = 71888;
	int k, r;
	tcc_core i_tcc_core (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
		.RDATA(rdata), .SLOW_CLOCK(slow_clock), .CLOCK_PIN(clock_pin), .IO_LINE_A_IN(a_in),
		.IO_LINE_A_OUT(a_out), .IO_LINE_A_OE(a_oe), .IO_LINE_B_IN(b_in), .IO_LINE_B_OUT(b_out),
		.IO_LINE_B_OE(b_oe), .IRQ(irq));
	tcc_ext_model i_tcc_ext_model (.mclk(mclk), .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
		.slow_clock(slow_clock), .clock_pin(clock_pin), .a_in(a_in), .b_in(b_in));
	// 100 ns clock
	always #50 mclk = ~mclk;
	// expected tick period of each source
	function automatic int div_of(input int s);
		return (s < 4) ? (2 << (2 * s)) : 32;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			n_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
		chk((g >= lo && g <= hi) ? lo : g, lo);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge mclk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [AW-1:0] a, output logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge mclk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic end_sim();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// watchdog well beyond the expected run
	initial begin
		#1000000;
		n_errors++;
		end_sim();
	end
	// main sequence
	initial begin
		cyc(16);
		rst_n <= 1'b1;
		cyc(2);
		rd(9'h020, d);
		chk(d, 32'h0);
		chk(32'(a_oe | b_oe), 32'h0);
		rd(9'h008, d);
		chk(d, 32'h0);
		wr(9'h000, 32'h1);
		rd(9'h020, d);
		chk(d[16], 1'b1);
		// each internal source and the slow clock, about eight ticks
		for (int s = 0; s < 5; s++) begin
			wr(9'h004, s);
			wr(9'h000, 32'h4);
			cyc(8 * div_of(s));
			rd(9'h010, d);
			rng(d, 32'h5, 32'h8);
		end
		// live reads while counting
		wr(9'h004, 32'h0);
		wr(9'h000, 32'h4);
		cyc(20);
		rd(9'h010, d);
		cyc(20);
		rd(9'h010, e);
		rng(e - d, 32'ha, 32'hc);
		// disabled: frozen, trigger ignored
		wr(9'h000, 32'h2);
		rd(9'h010, d);
		wr(9'h000, 32'h4);
		cyc(20);
		rd(9'h010, e);
		chk(e, d);
		rd(9'h020, e);
		chk(e[16], 1'b0);
		// burst on xc0 held low stops counting
		wr(9'h004, 32'h10);
		wr(9'h000, 32'h1);
		wr(9'h000, 32'h4);
		cyc(20);
		rd(9'h010, d);
		cyc(20);
		rd(9'h010, e);
		chk(e, d);
		// xc0 from clock pin, then chained from io line a of channel 1
		for (int c = 0; c < 2; c++) begin
			k = 2 + {$random(seed)} % 8;
			wr(9'h0c4, c);
			wr(9'h004, 32'h5);
			wr(9'h000, 32'h4);
			i_tcc_ext_model.pulse(c, c, k);
			rd(9'h010, d);
			chk(d, k - 1);
		end
		// waveform direction
		wr(9'h004, 32'h8000);
		cyc(3);
		chk({a_oe[0], b_oe[0]}, 2'b11);
		chk(32'(b_out), 32'h0);
		wr(9'h004, 32'h8200);
		cyc(3);
		chk({a_oe[0], b_oe[0]}, 2'b10);
		// compare c halts, then disables
		r = 4 + {$random(seed)} % 16;
		wr(9'h004, 32'h0);
		wr(9'h01c, r);
		wr(9'h004, 32'h8400);
		wr(9'h000, 32'h4);
		cyc(2 * r + 40);
		rd(9'h010, d);
		rng(d, r, r + 1);
		cyc(20);
		rd(9'h010, e);
		chk(e, d);
		lvl = a_out[0];
		wr(9'h004, 32'h8800);
		wr(9'h000, 32'h4);
		cyc(2 * r + 40);
		chk(a_out[0] ^ lvl, 1'b1);
		rd(9'h020, e);
		chk(e[16], 1'b0);
		// capture b load disables
		wr(9'h004, 32'h80);
		wr(9'h000, 32'h1);
		wr(9'h000, 32'h4);
		cyc(20);
		i_tcc_ext_model.pulse(1, 0, 1);
		rd(9'h020, e);
		chk(e[16], 1'b0);
		// rising io line b as external trigger restarts the count
		wr(9'h004, 32'h100);
		wr(9'h000, 32'h1);
		cyc(40);
		i_tcc_ext_model.pulse(2, 0, 1);
		rd(9'h010, d);
		rng(d, 32'h4, 32'h7);
		// group sync starts channels 0 and 1 together
		wr(9'h004, 32'h0);
		wr(9'h044, 32'h0);
		wr(9'h000, 32'h1);
		wr(9'h040, 32'h1);
		wr(9'h0c0, 32'h1);
		cyc(40);
		rd(9'h010, d);
		rd(9'h050, e);
		rng(d, 32'hf, 32'h16);
		rng(e, d, d + 2);
		chk(32'(irq), 32'h0);
		// reset in mid-run clears counters, enables and directions
		cyc(1);
		rst_n <= 1'b0;
		cyc(2);
		rst_n <= 1'b1;
		cyc(2);
		rd(9'h010, d);
		chk(d, 32'h0);
		rd(9'h020, d);
		chk(d, 32'h0);
		chk(32'(a_oe | b_oe | a_out), 32'h0);
		end_sim();
	end
endmodule
